// *** tb/spc_checker.sv ***
/* Checker bound to the stop mode power control top module.
   Assumes one clock and a synchronous active-high srst. */
module spc_checker
   import spc_pkg::*;
(
   input wire logic           clk,
   input wire logic           srst,
   input wire spc_ctrl_type   ctrl,
   input wire logic           regulator_in_reg,
   input wire logic           powerdown_wake_acknowledge,
   input wire spc_reg_type    regulator_mode,
   input wire logic           ram_power_on,
   input wire logic           systems_power_on,
   input wire logic           reg_retain,
   input wire logic           pin_latch_en,
   input wire logic           core_halt,
   input wire logic           fetch_reset_vector,
   input wire logic           resume_after_stop,
   input wire logic           ack_readback,
   input wire spc_status_type status
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Resume cycles are excluded, so only a true run cycle takes a stop
   wire go = !core_halt && !fetch_reset_vector && !resume_after_stop && ctrl.stop_exec;
   AST_NO_FULL: assert property (go && ctrl.req inside {SPC_REQ_NONE, SPC_REQ_FULL}
      |=> !core_halt && regulator_mode == SPC_REG_FULL) else $error("stop taken wrongly");
   AST_DEEP_IN: assert property (go && ctrl.req == SPC_REQ_DEEP
      |=> regulator_mode == SPC_REG_OFF && pin_latch_en && !systems_power_on) else $error("deep");
   AST_LIGHT_IN: assert property (go && ctrl.req == SPC_REQ_LIGHT
      |=> regulator_mode == SPC_REG_LOOSE && reg_retain && core_halt) else $error("light");
   AST_FIXED: assert property (ram_power_on && !ack_readback) else $error("ram or ack");
   AST_REG_GOOD: assert property (fetch_reset_vector || resume_after_stop
      |-> $past(regulator_in_reg, 2)) else $error("resumed before regulator good");
   AST_VECTOR: assert property (fetch_reset_vector
      |=> status.powerdown_wake_flag && !core_halt) else $error("flag not set");
   AST_HOLD: assert property (status.powerdown_wake_flag && !powerdown_wake_acknowledge
      |=> status.powerdown_wake_flag) else $error("flag lost");
   AST_ACK: assert property (powerdown_wake_acknowledge && !fetch_reset_vector && !go
      |=> !status.powerdown_wake_flag && !pin_latch_en) else $error("ack ignored");
   cover property (fetch_reset_vector);
   cover property (resume_after_stop);
   cover property (status.powerdown_wake_flag ##1 !status.powerdown_wake_flag);
endmodule
bind spc_stop_mode_power_control spc_checker i_spc_checker (.*);

// *** tb/tb_stop_mode_power_control.sv ***
/* Self-checking bench with a reference model of flag and pin latch.
   Assumes the checker file is compiled alongside and binds itself. */
module tb_stop_mode_power_control
   import spc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic           clk = 1'b0;
   logic           srst = 1'b1;
   logic           regulator_in_reg = 1'b0;
   logic           powerdown_wake_acknowledge = 1'b0;
   spc_ctrl_type   ctrl = '0;
   spc_reg_type    regulator_mode;
   spc_status_type status;
   logic           ram_power_on, systems_power_on, reg_retain, pin_latch_en, core_halt;
   logic           fetch_reset_vector, resume_after_stop, ack_readback, exp_flag, exp_latch;
   logic [31:0]    lfsr_q = 32'h3f86;
   int             error_cnt = 0;
   int             samples_checked = 0;
   spc_req_type    plan_q[$];
   always #2.5 clk = ~clk;
   spc_stop_mode_power_control i_spc_stop_mode_power_control (.*);
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic ok);
      samples_checked++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("FAIL %0t output differs from model", $time);
      end
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic rst(input int n);
      srst = 1'b1;
      repeat (n) @(negedge clk);
      srst = 1'b0;
      exp_flag = RST_WAKE_FLAG;
      exp_latch = RST_PIN_HOLD;
      chk(status.powerdown_wake_flag === exp_flag && pin_latch_en === exp_latch);
   endtask
   task automatic op(input spc_req_type m);
      logic deep, run;
      int n;
      deep = (m == SPC_REQ_DEEP);
      run = deep || m == SPC_REQ_LIGHT;
      ctrl = '{m, 1'b1, 1'b0};
      regulator_in_reg = 1'b0;
      @(negedge clk);
      ctrl.stop_exec = 1'b0;
      exp_latch = exp_latch | deep;
      chk(regulator_mode === (deep ? SPC_REG_OFF : run ? SPC_REG_LOOSE : SPC_REG_FULL));
      chk(core_halt === run && pin_latch_en === exp_latch && reg_retain === !deep);
      chk(systems_power_on === !deep && status.regs_retained === !deep && ram_power_on === 1'b1 && status.pins_latched === exp_latch);
      if (run) begin
         repeat (3) @(negedge clk);
         ctrl.wake_event = 1'b1;
         repeat (8) @(negedge clk);
         chk(core_halt === 1'b1 && fetch_reset_vector === 1'b0);
         regulator_in_reg = 1'b1;
         for (n = 0; n < 20 && fetch_reset_vector !== 1'b1 && resume_after_stop !== 1'b1; n++)
            @(negedge clk);
         chk(n < 20 && fetch_reset_vector === deep && resume_after_stop === !deep);
         ctrl.wake_event = 1'b0;
         @(negedge clk);
         exp_flag = exp_flag | deep;
         chk(core_halt === 1'b0 && status.powerdown_wake_flag === exp_flag);
      end
      lfsr_q = nxt(lfsr_q);
      powerdown_wake_acknowledge = lfsr_q[0];
      @(negedge clk);
      powerdown_wake_acknowledge = 1'b0;
      exp_flag = exp_flag & !lfsr_q[0];
      exp_latch = exp_latch & !lfsr_q[0];
      chk(status.powerdown_wake_flag === exp_flag && pin_latch_en === exp_latch);
      chk(ack_readback === 1'b0 && status.pins_latched === exp_latch);
   endtask
   initial begin
      rst(16);
      for (int i = 0; i < 4; i++) plan_q.push_back(spc_req_type'(i));
      repeat (12) begin
         lfsr_q = nxt(lfsr_q);
         plan_q.push_back(spc_req_type'(lfsr_q[2:1]));
      end
      while (plan_q.size() > 0) op(plan_q.pop_front());
      rst(3);
      tally_and_finish();
   end
endmodule

// *** verilog/spc_pkg.sv ***
/*
 * Package for the stop mode power control block: mode encodings, the
 * sequencer states and the control and status carriers.
 * Assumes one system clock and a synchronous active-high reset.
 */
package spc_pkg;

   // ----------------------------------------------------------------
   // Modes that software may request
   // ----------------------------------------------------------------
   localparam int  MODE_W = 2;
   typedef enum logic [1:0] {
      SPC_REQ_NONE  = 2'h0,
      SPC_REQ_LIGHT = 2'h1,
      SPC_REQ_DEEP  = 2'h2,
      SPC_REQ_FULL  = 2'h3
   } spc_req_type;

   // ----------------------------------------------------------------
   // Sequencer states, not Gray coded: run to deep, light to wake and resume to run each flip two bits
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SPC_RUN        = 3'h0,
      SPC_LIGHT_STOP = 3'h1,
      SPC_DEEP_STOP  = 3'h3,
      SPC_WAKE_WAIT  = 3'h2,
      SPC_RESUME     = 3'h6
   } spc_state_type;

   // ----------------------------------------------------------------
   // Regulator settings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SPC_REG_FULL  = 2'h0,
      SPC_REG_LOOSE = 2'h1,
      SPC_REG_OFF   = 2'h2
   } spc_reg_type;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic RST_WAKE_FLAG = 1'b0;
   localparam logic RST_PIN_HOLD  = 1'b0;
   localparam logic RST_DEEP_WAKE = 1'b0;

   // Request and wake inputs travel together
   typedef struct packed {
      spc_req_type req;
      logic        stop_exec;
      logic        wake_event;
   } spc_ctrl_type;

   // Status seen by software and the core
   typedef struct packed {
      logic powerdown_wake_flag;
      logic pins_latched;
      logic regs_retained;
   } spc_status_type;

endpackage

// *** verilog/spc_stop_mode_power_control.sv ***
/*
 * Stop mode sequencer: light stop and deep partial power-down stop,
 * regulator control, pin latch control and the wake flag.
 * Assumes the core, regulator and pins live outside; the wake source and
 * regulator good are asynchronous to clk, everything else is on clk.
 */
// Sequence overview
//   run        : core executes, regulator in full regulation
//   light stop : regulator loose, RAM and registers retained
//   deep stop  : regulator off, systems off, pins held latched
//   wake wait  : wake seen, waiting for the regulator to report good
//   resume     : one cycle, then back to run
// A light stop resumes after the stop instruction; a deep stop resumes
// through the reset vector, because register state did not survive.
//
// Limitations
//   The wake source is a level; a pulse shorter than one clock may be
//   missed by the synchroniser, so the source must hold it until the
//   core enters the wake wait.
//   The full power-down request code is decoded only to be dropped; a
//   core that issues it simply keeps running.
//   The pin latch is engaged on the clock of deep stop entry, so pin
//   values sampled by the pad ring must be stable at the stop instruction.
module spc_stop_mode_power_control
   import spc_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           srst,
   input  wire spc_ctrl_type   ctrl,
   input  wire logic           regulator_in_reg,
   input  wire logic           powerdown_wake_acknowledge,
   output spc_reg_type         regulator_mode,
   output logic                ram_power_on,
   output logic                systems_power_on,
   output logic                reg_retain,
   output logic                pin_latch_en,
   output logic                core_halt,
   output logic                fetch_reset_vector,
   output logic                resume_after_stop,
   output logic                ack_readback,
   output spc_status_type      status
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Wake source and regulator good come from outside the clock domain.
   // Bit 0 carries the wake level, bit 1 the regulator good level.
   localparam int SYNC_W = 2;

   logic [SYNC_W-1:0] async_in;
   logic [SYNC_W-1:0] sync_meta_q;
   logic [SYNC_W-1:0] sync_out_q;

   assign async_in = {regulator_in_reg, ctrl.wake_event};

   for (genvar b = 0; b < SYNC_W; b++) begin : g_sync
      // Only the second stage is read, so a metastable first stage
      // never reaches the sequencer
      always_ff @(posedge clk) begin
         sync_meta_q[b] <= async_in[b];
         sync_out_q[b]  <= sync_meta_q[b];
      end
   end

   wire logic wake_seen  = sync_out_q[0];
   wire logic regok_seen = sync_out_q[1];

   // ----------------------------------------------------------------
   // State and flags
   // ----------------------------------------------------------------
   spc_state_type state_q;
   spc_state_type state_d;
   logic          wake_flag_q;
   logic          wake_flag_d;
   logic          pin_hold_q;
   logic          pin_hold_d;
   logic          deep_wake_q;
   logic          deep_wake_d;

   wire logic go_light  = ctrl.stop_exec && (ctrl.req == SPC_REQ_LIGHT);
   wire logic go_deep   = ctrl.stop_exec && (ctrl.req == SPC_REQ_DEEP);
   // No path exists into full power-down; such a request is dropped
   wire logic in_stop   = (state_q == SPC_LIGHT_STOP) || (state_q == SPC_DEEP_STOP);
   wire logic resume_ev = (state_q == SPC_RESUME);
   wire logic wake_set  = resume_ev && deep_wake_q;
   wire logic ack_wr    = powerdown_wake_acknowledge;

   always_comb begin
      state_d     = state_q;
      deep_wake_d = deep_wake_q;
      case (state_q)
         SPC_RUN: begin
            if (go_light) begin
               state_d     = SPC_LIGHT_STOP;
               deep_wake_d = 1'b0;
            end else if (go_deep) begin
               state_d     = SPC_DEEP_STOP;
               deep_wake_d = 1'b1;
            end
         end
         SPC_LIGHT_STOP,
         SPC_DEEP_STOP: begin
            if (wake_seen) begin
               state_d = SPC_WAKE_WAIT;
            end
         end
         SPC_WAKE_WAIT: begin
            // No fixed cycle count: hold until regulation is good
            if (regok_seen) begin
               state_d = SPC_RESUME;
            end
         end
         SPC_RESUME: begin
            state_d = SPC_RUN;
         end
         default: begin
            state_d = SPC_RUN;
         end
      endcase
   end

   // Set beats a simultaneous acknowledge so a wake is never lost
   assign wake_flag_d = wake_set ? 1'b1 : (ack_wr ? 1'b0 : wake_flag_q);
   // Deep entry also wins over a simultaneous acknowledge, so the pins
   // are never released on the very clock they are meant to be held
   wire logic take_deep = go_deep && (state_q == SPC_RUN);
   assign pin_hold_d  = take_deep ? 1'b1 :
                        (ack_wr ? 1'b0 : pin_hold_q);

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q     <= SPC_RUN;
         wake_flag_q <= RST_WAKE_FLAG;
         pin_hold_q  <= RST_PIN_HOLD;
         deep_wake_q <= RST_DEEP_WAKE;
      end else begin
         state_q     <= state_d;
         wake_flag_q <= wake_flag_d;
         pin_hold_q  <= pin_hold_d;
         deep_wake_q <= deep_wake_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // State decode shared by the regulator, power, retain and halt outputs
   wire logic st_light = (state_q == SPC_LIGHT_STOP);
   wire logic st_deep  = (state_q == SPC_DEEP_STOP);
   wire logic st_wait  = (state_q == SPC_WAKE_WAIT);

   // Systems stay off through the wake wait of a deep stop: the
   // regulator is still ramping and register state is already gone
   wire logic deep_pd = st_deep || (st_wait && deep_wake_q);

   // Regulator selection; the wake wait asks for full regulation so
   // the regulator can ramp while the core is still halted
   wire spc_reg_type reg_sel = st_deep  ? SPC_REG_OFF :
                               st_light ? SPC_REG_LOOSE :
                               SPC_REG_FULL;

   assign regulator_mode     = reg_sel;
   assign ram_power_on       = 1'b1;
   assign systems_power_on   = !deep_pd;
   assign reg_retain         = !deep_pd;
   assign pin_latch_en       = pin_hold_q;
   assign core_halt          = in_stop || st_wait;
   assign fetch_reset_vector = resume_ev && deep_wake_q;
   assign resume_after_stop  = resume_ev && !deep_wake_q;
   assign ack_readback       = 1'b0;
   // Software tells deep wake from a plain reset by this flag
   assign status.powerdown_wake_flag = wake_flag_q;
   assign status.pins_latched        = pin_hold_q;
   assign status.regs_retained       = !deep_pd;

endmodule
